// ==== rtl/lasc_crc.sv ====
// constants and multiframe crc accumulator for the line activation codec
`timescale 1ns/1ps
package lasc_pkg;
    // ****************************************
    // widths
    // ****************************************
    localparam int DN_W  = 10;
    localparam int UP_W  = 12;
    localparam int BD_W  = 18;
    localparam int CRC_W = 12;
    localparam int FR_W  = UP_W + BD_W;

    // ****************************************
    // cl channel bit positions, received direction
    // ****************************************
    localparam int DN_OFS = 0;
    localparam int DN_AR  = 1;
    localparam int DN_DR  = 2;
    localparam int DN_AP  = 3;
    localparam int DN_H   = 4;
    localparam int DN_S   = 7;

    // ****************************************
    // cl channel bit positions, sent direction
    // ****************************************
    localparam int UP_AI   = 0;
    localparam int UP_T    = 1;
    localparam int UP_FEBE = 4;
    localparam int UP_Q    = 5;

    // ****************************************
    // received signal patterns: care mask and value
    // ****************************************
    localparam logic [DN_W-1:0] SIG6_MASK = 10'h37D;
    localparam logic [DN_W-1:0] SIG6_VAL  = 10'h001;
    localparam logic [DN_W-1:0] SIG7_MASK = 10'h37D;
    localparam logic [DN_W-1:0] SIG7_VAL  = 10'h009;
    localparam logic [DN_W-1:0] SIG9_MASK = 10'h37F;
    localparam logic [DN_W-1:0] SIG9_VAL  = 10'h071;
    localparam logic [DN_W-1:0] DN_ZERO   = 10'h000;

    // ****************************************
    // sent signal templates, febe merged later into all but SIG5_CL, q merged later into SIG10_CL and SIG11_CL only
    // ****************************************
    localparam logic [UP_W-1:0] SIG5_CL  = 12'h000;
    localparam logic [UP_W-1:0] SIG8_CL  = 12'h1E1;
    localparam logic [UP_W-1:0] SIG10_CL = 12'h00F;
    localparam logic [UP_W-1:0] SIG11_CL = 12'h001;
    localparam logic [UP_W-1:0] SIG12_CL = 12'h1EE;
    localparam logic [UP_W-1:0] SIG14_CL = 12'h1E0;
    localparam logic [BD_W-1:0] BD_ONES  = 18'h3_FFFF;
    localparam logic [BD_W-1:0] BD_ZERO  = 18'h0_0000;

    localparam logic [CRC_W-1:0] CRC_POLY = 12'h80F;
    localparam logic [CRC_W-1:0] CRC_INIT = 12'h000;

    typedef enum logic [2:0] {
        ST_DOWN, ST_SYNC, ST_TRAIN, ST_TACT, ST_NORM, ST_LBACT, ST_LB
    } lasc_st_t;
endpackage

module lasc_crc (
    input  wire logic                      ref_clk,
    input  wire logic                      rst_n,
    input  wire logic                      en,
    input  wire logic                      clr,
    input  wire logic [lasc_pkg::FR_W-1:0] data,
    output logic      [lasc_pkg::CRC_W-1:0] crc
);
    import lasc_pkg::*;

    // one frame folded in per enable, msb first
    function automatic logic [CRC_W-1:0] crc_step(
        input logic [CRC_W-1:0] c,
        input logic [FR_W-1:0]  d
    );
        logic [CRC_W-1:0] r;
        logic             fb;
        r = c;
        for (int i = FR_W - 1; i >= 0; i--) begin
            fb = r[CRC_W-1] ^ d[i];
            r  = {r[CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : CRC_INIT);
        end
        return r;
    endfunction

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            crc <= CRC_INIT;
        end else if (en) begin
            crc <= crc_step(clr ? CRC_INIT : crc, data);
        end
    end
endmodule

// ==== rtl/lasc_nt.sv ====
// network-end activation signal codec: decodes line signals, builds replies
`timescale 1ns/1ps

module lasc_nt (
    input  wire logic                        ref_clk,
    input  wire logic                        rst_n,
    input  wire logic                        awake_pol,
    input  wire logic                        info1_rx,
    input  wire logic                        info3_rx,
    input  wire logic                        frame_en,
    input  wire logic                        mf_en,
    input  wire logic                        rx_sync,
    input  wire logic [lasc_pkg::DN_W-1:0]   rx_cl,
    input  wire logic [lasc_pkg::BD_W-1:0]   rx_bd,
    input  wire logic [lasc_pkg::CRC_W-1:0]  rx_crc,
    input  wire logic [lasc_pkg::BD_W-1:0]   user_bd,
    input  wire logic [3:0]                  user_q,
    output logic                             awake_req,
    output logic                             pwr_up,
    output logic                             send_info2,
    output logic                             send_info4,
    output logic                             lb2_on,
    output logic                             tx_on,
    output logic                             tx_train,
    output logic                             tx_m,
    output logic                             tx_p,
    output logic      [lasc_pkg::UP_W-1:0]   tx_cl,
    output logic      [lasc_pkg::BD_W-1:0]   tx_bd,
    output logic      [lasc_pkg::CRC_W-1:0]  tx_crc
);
    import lasc_pkg::*;

    typedef struct packed {
        logic [2:0]       aw_sync;
        logic             awake;
        lasc_st_t         st;
        logic             febe;
        logic [3:0]       q_lp;
        logic             sig2a;
        logic             pwr_up;
        logic             info2;
        logic             info4;
        logic             lb2;
        logic             tx_on;
        logic             tx_train;
        logic             tx_m;
        logic             tx_p;
        logic [UP_W-1:0]  tx_cl;
        logic [BD_W-1:0]  tx_bd;
        logic [CRC_W-1:0] tx_crc;
    } lasc_state_t;

    lasc_state_t      s_r;
    lasc_state_t      s_nxt;
    logic [CRC_W-1:0] tx_acc;
    logic [CRC_W-1:0] rx_acc;

    function automatic logic sig_match(
        input logic [DN_W-1:0] cl,
        input logic [DN_W-1:0] mask,
        input logic [DN_W-1:0] val
    );
        return (cl & mask) == val;
    endfunction

    // ****************************************
    // crc over sent and received frames
    // ****************************************
    lasc_crc u_tx_crc (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .en      (frame_en && s_nxt.tx_on),
        .clr     (mf_en),
        .data    ({s_nxt.tx_cl, s_nxt.tx_bd}),
        .crc     (tx_acc)
    );

    lasc_crc u_rx_crc (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .en      (frame_en),
        .clr     (mf_en),
        .data    ({rx_cl, rx_bd}),
        .crc     (rx_acc)
    );

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        logic            is4;
        logic            is6;
        logic            is7;
        logic            is9;
        logic [UP_W-1:0] fb;
        s_nxt   = s_r;
        is4     = rx_sync && (rx_cl == DN_ZERO);
        is6     = sig_match(rx_cl, SIG6_MASK, SIG6_VAL);
        is7     = sig_match(rx_cl, SIG7_MASK, SIG7_VAL);
        is9     = sig_match(rx_cl, SIG9_MASK, SIG9_VAL);
        fb      = '0;
        fb[UP_FEBE] = s_r.febe;
        // only the second and third stages are compared
        s_nxt.aw_sync = {s_r.aw_sync[1:0], awake_pol};
        if (s_r.aw_sync[1] == s_r.aw_sync[2]) begin
            s_nxt.awake = s_r.aw_sync[2];
        end
        if (!s_r.awake) begin
            if (s_r.st != ST_DOWN) begin
                s_nxt = '0;
                s_nxt.aw_sync = {s_r.aw_sync[1:0], awake_pol};
            end else begin
                s_nxt.sig2a = s_r.sig2a | info1_rx;
            end
        end else if (s_r.st == ST_DOWN) begin
            s_nxt.st     = ST_SYNC;
            s_nxt.pwr_up = 1'b1;
        end else if (frame_en) begin
            s_nxt.tx_m = ~s_r.tx_m;
            if (s_r.st != ST_SYNC && !rx_sync) begin
                s_nxt.st = ST_SYNC;
            end else if (s_r.st == ST_SYNC) begin
                if (is4) begin
                    s_nxt.st = ST_TRAIN;
                end
            end else if (mf_en) begin
                // pattern judged once per multiframe
                if (is6) begin
                    s_nxt.st = ST_TACT;
                end else if (is7) begin
                    s_nxt.st = ST_NORM;
                end else if (is9) begin
                    s_nxt.st = (s_r.st == ST_LBACT || s_r.st == ST_LB) ?
                               ST_LB : ST_LBACT;
                end
            end
            if (mf_en) begin
                s_nxt.febe   = (rx_crc == rx_acc);
                s_nxt.tx_crc = tx_acc;
            end
            s_nxt.q_lp     = {s_r.q_lp[2:0], rx_cl[DN_S]};
            s_nxt.tx_on    = (s_r.st != ST_SYNC);
            s_nxt.tx_train = 1'b0;
            s_nxt.tx_bd    = BD_ONES;
            unique case (s_r.st)
                ST_DOWN, ST_SYNC: begin
                    s_nxt.tx_cl = SIG5_CL;
                    s_nxt.tx_bd = BD_ZERO;
                end
                ST_TRAIN: begin
                    s_nxt.tx_train = 1'b1;
                    s_nxt.tx_cl    = SIG5_CL;
                    s_nxt.tx_bd    = BD_ZERO;
                end
                ST_TACT: begin
                    // info3 indication selects SIG8_CL over SIG14_CL
                    s_nxt.tx_cl = info3_rx ? (SIG8_CL | fb)
                                           : (SIG14_CL | fb);
                end
                ST_NORM: begin
                    s_nxt.tx_cl = SIG11_CL | fb;
                    s_nxt.tx_cl[UP_Q +: 4] = user_q;
                    s_nxt.tx_bd = user_bd;
                end
                ST_LBACT: begin
                    s_nxt.tx_cl = SIG12_CL | fb;
                end
                ST_LB: begin
                    s_nxt.tx_cl = SIG10_CL | fb;
                    s_nxt.tx_cl[UP_Q +: 4] = s_nxt.q_lp;
                    s_nxt.tx_bd = rx_bd;
                end
            endcase
            s_nxt.tx_p = s_nxt.tx_train ? s_nxt.tx_m
                                        : ^s_nxt.tx_cl;
        end
        s_nxt.info2 = (s_nxt.st == ST_TACT)
                   || (s_nxt.st == ST_NORM && !info3_rx);
        s_nxt.info4 = (s_nxt.st == ST_NORM) && info3_rx;
        s_nxt.lb2   = (s_nxt.st == ST_LB);
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign awake_req  = s_r.sig2a;
    assign pwr_up     = s_r.pwr_up;
    assign send_info2 = s_r.info2;
    assign send_info4 = s_r.info4;
    assign lb2_on     = s_r.lb2;
    assign tx_on      = s_r.tx_on;
    assign tx_train   = s_r.tx_train;
    assign tx_m       = s_r.tx_m;
    assign tx_p       = s_r.tx_p;
    assign tx_cl      = s_r.tx_cl;
    assign tx_bd      = s_r.tx_bd;
    assign tx_crc     = s_r.tx_crc;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence enter_sync;
        s_r.st == ST_DOWN && s_r.awake;
    endsequence

    sequence powered_sync;
        s_r.st == ST_SYNC && pwr_up;
    endsequence

    wake_up_sync_a: assert property (
        enter_sync |=> powered_sync)
        else $error("awake did not start sync");
    power_down_a: assert property (
        s_r.st != ST_DOWN && !s_r.awake |=> s_r.st == ST_DOWN && !pwr_up)
        else $error("deactivate did not power down");
    train_wait_a: assert property (
        frame_en && s_r.st == ST_SYNC && !(rx_sync && rx_cl == DN_ZERO)
        |=> s_r.st == ST_SYNC ##1 !tx_train)
        else $error("training sent before sync");
    train_frame_a: assert property (
        frame_en && s_r.st == ST_TRAIN && s_r.awake && rx_sync
        |=> tx_cl == SIG5_CL && tx_train && tx_p == tx_m
            && tx_m != $past(tx_m))
        else $error("bad training frame");
    sig6_decode_a: assert property (
        frame_en && mf_en && s_r.awake && s_r.st == ST_TRAIN && rx_sync
        && sig_match(rx_cl, SIG6_MASK, SIG6_VAL)
        |=> s_r.st == ST_TACT && send_info2)
        else $error("line active signal not acted on");
    info4_gate_a: assert property (
        send_info4 |-> s_r.st == ST_NORM && $past(info3_rx))
        else $error("info4 without normal signal and info3");
    sig8_bits_a: assert property (
        frame_en && s_r.awake && rx_sync && s_r.st == ST_TACT && info3_rx
        |=> tx_cl[UP_AI] && tx_cl[UP_Q +: 4] == 4'hF
            && tx_cl[UP_T +: 3] == 3'h0)
        else $error("info3 indication malformed");
    sig11_bits_a: assert property (
        frame_en && s_r.awake && rx_sync && s_r.st == ST_NORM
        |=> tx_cl[UP_AI] && tx_cl[UP_T +: 3] == 3'h0 && tx_bd == $past(user_bd))
        else $error("normal reply malformed");
    sig12_bits_a: assert property (
        frame_en && s_r.awake && rx_sync && s_r.st == ST_LBACT
        |=> tx_cl[UP_T +: 3] == 3'h7 && !tx_cl[UP_AI] && tx_bd == BD_ONES)
        else $error("loopback activating malformed");
    loop_data_a: assert property (
        frame_en && s_r.awake && rx_sync && s_r.st == ST_LB
        |=> tx_bd == $past(rx_bd) && tx_cl[UP_Q] == $past(rx_cl[DN_S]))
        else $error("loopback data not returned");
endmodule

// ==== verif/lasc_lt_model.sv ====
// far line-end model: frame timing and line signal patterns
`timescale 1ns/1ps
module lasc_lt_model (
    input  wire logic                       ref_clk,
    input  wire logic                       rst_n,
    input  wire logic                       awake,
    input  wire logic                       sync,
    input  wire logic [3:0]                 sig,
    input  wire logic                       ar,
    input  wire logic                       s_bit,
    input  wire logic                       crc_err,
    input  wire logic                       tx_on,
    input  wire logic [lasc_pkg::UP_W-1:0]  tx_cl,
    input  wire logic [lasc_pkg::BD_W-1:0]  tx_bd,
    output logic                            awake_pol,
    output logic                            frame_en,
    output logic                            mf_en,
    output logic                            rx_sync,
    output logic      [lasc_pkg::DN_W-1:0]  rx_cl,
    output logic      [lasc_pkg::BD_W-1:0]  rx_bd,
    output logic      [lasc_pkg::CRC_W-1:0] rx_crc,
    output logic      [lasc_pkg::CRC_W-1:0] exp_tx_crc
);
    import lasc_pkg::*;
    logic [4:0]       cnt;
    logic [DN_W-1:0]  pat;
    logic [BD_W-1:0]  bd_base;
    logic [CRC_W-1:0] rx_sum;
    logic [CRC_W-1:0] tx_sum;
    logic             fe_d;
    logic             mf_d;
    // one frame folded in, msb first
    function automatic logic [CRC_W-1:0] fold(
        input logic [CRC_W-1:0] c,
        input logic [FR_W-1:0]  d
    );
        logic [CRC_W-1:0] r;
        r = c;
        for (int i = FR_W - 1; i >= 0; i--) begin
            r = {r[CRC_W-2:0], 1'b0}
                ^ ((r[CRC_W-1] ^ d[i]) ? CRC_POLY : CRC_INIT);
        end
        return r;
    endfunction
    assign awake_pol = awake;
    assign rx_sync   = sync;
    // inverted on request so that a febe mismatch report can be provoked
    assign rx_crc    = crc_err ? ~rx_sum : rx_sum;
    // ****************************************
    // cl pattern per signal kind
    // ****************************************
    always_comb begin
        pat = DN_ZERO;
        case (sig)
            4'h6: pat = {2'b00, s_bit, 5'b0_0000, ar, 1'b1};
            4'h7: pat = {2'b00, s_bit, 4'b0001, 1'b0, ar, 1'b1};
            4'h9: pat = {2'b00, s_bit, 5'b1_1100, 1'b0, 1'b1};
            default: ;
        endcase
    end
    // ****************************************
    // frame timing: 8 cycles a frame, 4 frames a multiframe
    // ****************************************
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt      <= 5'h00;
            frame_en <= 1'b0;
            mf_en    <= 1'b0;
            rx_cl    <= 10'h2AA;
            rx_bd    <= 18'h0_0000;
            bd_base  <= 18'h1_2345;
            rx_sum     <= CRC_INIT;
            tx_sum     <= CRC_INIT;
            exp_tx_crc <= CRC_INIT;
            fe_d       <= 1'b0;
            mf_d       <= 1'b0;
        end else begin
            cnt      <= #1 cnt + 5'h01;
            frame_en <= #1 awake && cnt[2:0] == 3'h7;
            mf_en    <= #1 awake && cnt == 5'h1F;
            // no framed signal: cl lines wander so stale values never match
            rx_cl    <= #1 awake ? pat : ~rx_cl;
            // data only valid in the frame_en cycle, inverted elsewhere
            rx_bd    <= #1 (cnt[2:0] == 3'h7) ? bd_base : ~bd_base;
            if (cnt[2:0] == 3'h7) begin
                bd_base <= #1 bd_base + 18'h0_4C3B;
            end
            // line crc over the frames of one multiframe
            if (frame_en) begin
                rx_sum <= #1 fold(mf_en ? CRC_INIT : rx_sum,
                                  {rx_cl, rx_bd});
            end
            // sent frames are settled one cycle after their frame pulse
            if (frame_en && mf_en) begin
                exp_tx_crc <= #1 tx_sum;
            end
            if (fe_d && tx_on) begin
                tx_sum <= #1 fold(mf_d ? CRC_INIT : tx_sum, {tx_cl, tx_bd});
            end
            fe_d <= #1 frame_en;
            mf_d <= #1 mf_en;
        end
    end
endmodule

// ==== verif/lasc_nt_tb.sv ====
// self-checking bench for the network-end activation codec
`timescale 1ns/1ps
module lasc_nt_tb;
    import lasc_pkg::*;
    logic             ref_clk, rst_n, awake, sync, ar, s_bit;
    logic             info1_rx, info3_rx, awake_pol, frame_en, mf_en;
    logic             rx_sync, awake_req, pwr_up, send_info2, send_info4;
    logic             lb2_on, tx_on, tx_train, tx_m, tx_p, m0, crc_err;
    logic [3:0]       sig, user_q;
    logic [DN_W-1:0]  rx_cl;
    logic [BD_W-1:0]  rx_bd, user_bd, tx_bd, cap_bd;
    logic [CRC_W-1:0] rx_crc, tx_crc, exp_tx_crc;
    logic [UP_W-1:0]  tx_cl;
    int               fails, cmp_count;

    lasc_lt_model lasc_lt_model_i (.ref_clk, .rst_n, .awake, .sync, .sig,
        .ar, .s_bit, .crc_err, .tx_on, .tx_cl, .tx_bd, .awake_pol,
        .frame_en, .mf_en, .rx_sync, .rx_cl, .rx_bd, .rx_crc, .exp_tx_crc);
    lasc_nt lasc_nt_i (.ref_clk, .rst_n, .awake_pol, .info1_rx, .info3_rx,
        .frame_en, .mf_en, .rx_sync, .rx_cl, .rx_bd, .rx_crc, .user_bd,
        .user_q, .awake_req, .pwr_up, .send_info2, .send_info4, .lb2_on,
        .tx_on, .tx_train, .tx_m, .tx_p, .tx_cl, .tx_bd, .tx_crc);

    // ****************************************
    // helpers
    // ****************************************
    task check(string name, logic [31:0] seen, logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task tick(int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // febe is left out: it depends on the line crc, not on the state
    function automatic logic [UP_W-1:0] cl_nf();
        return tx_cl & 12'hFEF;
    endfunction
    task frames(int n);
        repeat (n) @(posedge ref_clk iff frame_en);
        cap_bd = rx_bd;
        #1;
    endtask
    task wait_mf;
        @(posedge ref_clk iff mf_en);
        #1;
    endtask
    task finish_test;
        if (fails == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task t_wake;
        info1_rx = 1'b1;
        tick(3);
        check("awake_req", awake_req, 1);
        info1_rx = 1'b0;
        awake = 1'b1;
        tick(8);
        check("pwr_up", pwr_up, 1);
        check("awake_req held", awake_req, 1);
    endtask
    task t_train;
        frames(2);
        check("tx_on unsynced", tx_on, 0);
        sync = 1'b1;
        frames(2);
        check("tx_on", tx_on, 1);
        check("tx_train", tx_train, 1);
        check("train cl", tx_cl, 12'h000);
        check("train p", tx_p, tx_m);
        m0 = tx_m;
        frames(1);
        check("train m", tx_m, !m0);
        check("train p2", tx_p, tx_m);
    endtask
    task t_tact;
        sig = 4'h6;
        ar = 1'b1;
        s_bit = 1'b1;
        wait_mf;
        frames(1);
        check("send_info2", send_info2, 1);
        check("sig14 cl", cl_nf(), 12'h1E0);
        check("sig14 bd", tx_bd, 18'h3_FFFF);
        check("sig14 febe", tx_cl[UP_FEBE], 1);
        info3_rx = 1'b1;
        frames(1);
        check("sig8 cl", cl_nf(), 12'h1E1);
        check("sig8 bd", tx_bd, 18'h3_FFFF);
    endtask
    task t_norm;
        sig = 4'h7;
        s_bit = 1'b0;
        user_q = 4'hA;
        user_bd = 18'h2_5A5A;
        wait_mf;
        frames(1);
        check("send_info4", send_info4, 1);
        check("sig11 cl", cl_nf(), 12'h141);
        check("sig11 bd", tx_bd, user_bd);
        check("sig11 p", tx_p, ^tx_cl);
        info3_rx = 1'b0;
        tick(2);
        check("info4 off", send_info4, 0);
        check("info2 back", send_info2, 1);
    endtask
    task t_lb;
        sig = 4'h9;
        s_bit = 1'b1;
        crc_err = 1'b1;
        wait_mf;
        frames(1);
        check("sig12 cl", cl_nf(), 12'h1EE);
        check("sig12 bd", tx_bd, 18'h3_FFFF);
        check("febe bad", tx_cl[UP_FEBE], 0);
        crc_err = 1'b0;
        wait_mf;
        frames(4);
        check("lb2_on", lb2_on, 1);
        check("sig10 cl", cl_nf(), 12'h1EF);
        check("sig10 bd", tx_bd, cap_bd);
    endtask
    task t_down;
        sync = 1'b0;
        frames(2);
        check("tx_on lost", tx_on, 0);
        check("tx_crc", tx_crc, exp_tx_crc);
        awake = 1'b0;
        tick(6);
        check("down pwr", pwr_up, 0);
        check("down req", awake_req, 0);
        check("down lb", lb2_on, 0);
        check("down info2", send_info2, 0);
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    // hang guard: the tests need well under 2000 cycles
    initial begin
        #1000000;
        fails++;
        finish_test();
    end
    initial begin
        fails = 0;
        cmp_count = 0;
        rst_n = 1'b0;
        {awake, sync, ar, s_bit, info1_rx, info3_rx} = 6'b00_0000;
        crc_err = 1'b0;
        sig = 4'h4;
        user_q = 4'h0;
        user_bd = 18'h0_0000;
        tick(16);
        check("reset outs", {awake_req, pwr_up, send_info2, send_info4,
            lb2_on, tx_on}, 0);
        rst_n = 1'b1;
        tick(1);
        t_wake();
        t_train();
        t_tact();
        t_norm();
        t_lb();
        t_down();
        finish_test();
    end
endmodule
